// File: design/frt_pkg.sv
// Constants and types for the floating-point register transfer block
// What this block does
// (RQ1) Condition codes: sign/zero compares, test, latched flags, always.
// (RQ2) Undefined condition codes are reserved; nothing may depend on them.
// (RQ3) A conditional move given no condition acts as unconditional with flag update.
// (RQ4) Only flag-updating moves touch zero/negative flags; other conditions change none.
// (RQ5) Flag update: negative = bit 31, zero clear; zero exponent sets zero, clears negative.
// (RQ6) Flag update: integer negative = bit 31; integer zero only for an all-zero word.
// (RQ7) Conditional register move finishes in one cycle; result usable next.
// (RQ8) Copy a whole CPU auxiliary register into a float register, flags untouched.
// (RQ9) Copy the CPU temporary multiplier register into a float register, flags untouched.
// (RQ10) CPU side waits four cycles, without conversions, before using a copied value.
// (RQ11) Copy a float register into a CPU auxiliary register, flags untouched.
// (RQ12) CPU side inserts one or two cycles before reading a just-computed float result.
// (RQ13) Loading the status word overwrites all seven flags in one cycle.
// (RQ14) Load-with-copy fills a float register, writes the word two higher, updates flags.
// (RQ15) Full float immediate is an upper-half load optionally followed by lower-half.
// (RQ16) Upper-half immediate writes bits 31:16 and clears bits 15:0, no flags.
// (RQ17) Lower-half immediate writes bits 15:0 and keeps bits 31:16, no flags.
package frt_pkg;

   // ----------------------------------------
   // Register map (byte addresses, low byte)
   // ----------------------------------------
   localparam logic [7:0]  ADDR_CMD   = 8'h00;
   localparam logic [7:0]  ADDR_OPND  = 8'h04;
   localparam logic [7:0]  ADDR_MADDR = 8'h08;
   localparam logic [7:0]  ADDR_STAT  = 8'h0C;
   localparam logic [7:0]  ADDR_COPYA = 8'h10;
   localparam logic [7:0]  ADDR_COPYD = 8'h14;
   localparam logic [7:0]  ADDR_TEMP  = 8'h18;
   localparam logic [2:0]  PAGE_FP    = 3'h1;
   localparam logic [2:0]  PAGE_AUX   = 3'h2;

   // ----------------------------------------
   // Sizes, field positions, reset values
   // ----------------------------------------
   localparam int          FP_N       = 8;
   localparam int          SIGN_BIT   = 31;
   localparam int          EXP_HI     = 30;
   localparam int          EXP_LO     = 23;
   localparam logic [31:0] COPY_STEP  = 32'h0000_0002;
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;

   // ----------------------------------------
   // Move conditions
   // ----------------------------------------
   localparam logic [3:0]  CND_NEQ    = 4'h0;
   localparam logic [3:0]  CND_EQ     = 4'h1;
   localparam logic [3:0]  CND_GT     = 4'h2;
   localparam logic [3:0]  CND_GEQ    = 4'h3;
   localparam logic [3:0]  CND_LT     = 4'h4;
   localparam logic [3:0]  CND_LEQ    = 4'h5;
   localparam logic [3:0]  CND_TSET   = 4'hA;
   localparam logic [3:0]  CND_TCLR   = 4'hB;
   localparam logic [3:0]  CND_LU     = 4'hC;
   localparam logic [3:0]  CND_LV     = 4'hD;
   localparam logic [3:0]  CND_ALW    = 4'hE;
   localparam logic [3:0]  CND_ALWF   = 4'hF;

   // ----------------------------------------
   // Operations issued through the command word
   // ----------------------------------------
   typedef enum logic [3:0] {
      OP_MOVE_RR    = 4'h0,
      OP_MOVE_MEM   = 4'h1,
      OP_AUX_TO_FP  = 4'h2,
      OP_TEMP_TO_FP = 4'h3,
      OP_FP_TO_AUX  = 4'h4,
      OP_LOAD_STAT  = 4'h5,
      OP_LOAD_COPY  = 4'h6,
      OP_IMM_HI     = 4'h7,
      OP_IMM_LO     = 4'h8
   } frt_op_t;

   typedef struct packed {
      logic test;
      logic izero;
      logic ineg;
      logic zero;
      logic neg;
      logic unf;
      logic ovf;
   } frt_flags_t;

   localparam frt_flags_t FLAGS_RST = 7'h00;

   typedef struct packed {
      logic [15:0] imm;
      logic        has_cond;
      logic [2:0]  src;
      logic        rsv;
      logic [2:0]  dest;
      logic [3:0]  cond;
      logic [3:0]  op;
   } frt_cmd_t;

endpackage

// File: design/frt_core.sv
// Floating-point register transfer unit with an AHB-Lite register port
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module frt_core
   import frt_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        en_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   output logic             copy_we_o,
   output logic [31:0]      copy_addr_o,
   output logic [31:0]      copy_data_o,
   output frt_flags_t       flags_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [31:0] fp_q  [FP_N];
   logic [31:0] fp_d  [FP_N];
   logic [31:0] aux_q [FP_N];
   logic [31:0] aux_d [FP_N];
   logic [31:0] tmp_q, tmp_d;
   logic [31:0] opnd_q, opnd_d;
   logic [31:0] maddr_q, maddr_d;
   frt_flags_t  flg_q, flg_d;
   logic        copy_we_q, copy_we_d;
   logic [31:0] copy_addr_q, copy_addr_d;
   logic [31:0] copy_data_q, copy_data_d;
   logic        wr_q, wr_d;
   logic [7:0]  addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;

   logic        take;
   logic        exec;
   frt_cmd_t    cmd;
   logic [3:0]  cnd_w;
   logic [2:0]  dest_w;
   logic [31:0] mv_src_w;
   logic        go_w;

   // ----------------------------------------
   // Condition test and flag update
   // ----------------------------------------
   function automatic logic cond_true(input logic [3:0] c,
                                      input frt_flags_t f);
      case (c)
         CND_NEQ:  cond_true = !f.zero;
         CND_EQ:   cond_true = f.zero;
         CND_GT:   cond_true = !f.zero && !f.neg;
         CND_GEQ:  cond_true = !f.neg;
         CND_LT:   cond_true = f.neg;
         CND_LEQ:  cond_true = f.zero || f.neg;
         CND_TSET: cond_true = f.test;
         CND_TCLR: cond_true = !f.test;
         CND_LU:   cond_true = f.unf;
         CND_LV:   cond_true = f.ovf;
         CND_ALW:  cond_true = 1'b1;
         CND_ALWF: cond_true = 1'b1;
         // (RQ2) reserved codes drop the move, safest outcome
         default:  cond_true = 1'b0;
      endcase
   endfunction

   function automatic frt_flags_t flag_update(input frt_flags_t f,
                                              input logic [31:0] w);
      frt_flags_t r;
      r = f;
      r.neg   = w[SIGN_BIT];
      r.zero  = 1'b0;
      if (w[EXP_HI:EXP_LO] == 8'h00) begin
         r.zero = 1'b1;
         r.neg  = 1'b0;
      end
      r.ineg  = w[SIGN_BIT];
      r.izero = (w == WORD_RST);
      flag_update = r;
   endfunction

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   // Frozen block stalls the bus rather than dropping transfers
   assign hreadyout_o = en_i;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_q;
   assign copy_we_o   = copy_we_q;
   assign copy_addr_o = copy_addr_q;
   assign copy_data_o = copy_data_q;
   assign flags_o     = flg_q;

   assign take = hsel_i && hready_i && htrans_i[1];
   assign exec = wr_q && en_i && (addr_q == ADDR_CMD);
   assign cmd  = frt_cmd_t'(hwdata_i);

   always_comb begin
      wr_d   = take && hwrite_i;
      addr_d = take ? haddr_i[7:0] : addr_q;
   end

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   always_comb begin
      dest_w = cmd.dest;
      // (RQ3) missing condition
      cnd_w  = cmd.has_cond ? cmd.cond : CND_ALWF;
      // (RQ1) condition decode
      go_w   = cond_true(cnd_w, flg_q);
      case (cmd.op)
         OP_MOVE_RR:    mv_src_w = fp_q[cmd.src];
         OP_AUX_TO_FP:  mv_src_w = aux_q[cmd.src];
         OP_TEMP_TO_FP: mv_src_w = tmp_q;
         OP_FP_TO_AUX:  mv_src_w = fp_q[cmd.src];
         OP_IMM_HI:     mv_src_w = {cmd.imm, 16'h0000};
         OP_IMM_LO:     mv_src_w = {fp_q[cmd.dest][31:16], cmd.imm};
         default:       mv_src_w = opnd_q;
      endcase
   end

   // ----------------------------------------
   // Register file and execution
   // ----------------------------------------
   always_comb begin
      fp_d        = fp_q;
      aux_d       = aux_q;
      tmp_d       = tmp_q;
      opnd_d      = opnd_q;
      maddr_d     = maddr_q;
      flg_d       = flg_q;
      copy_we_d   = 1'b0;
      copy_addr_d = copy_addr_q;
      copy_data_d = copy_data_q;
      if (wr_q) begin
         case (addr_q)
            ADDR_OPND:  opnd_d  = hwdata_i;
            ADDR_MADDR: maddr_d = hwdata_i;
            ADDR_TEMP:  tmp_d   = hwdata_i;
            default: begin
               if (addr_q[7:5] == PAGE_AUX) begin
                  aux_d[addr_q[4:2]] = hwdata_i;
               end
            end
         endcase
      end
      if (exec) begin
         case (cmd.op)
            OP_MOVE_RR, OP_MOVE_MEM: begin
               // (RQ7) single-cycle move
               if (go_w) begin
                  fp_d[dest_w] = mv_src_w;
               end
               // (RQ4) only flag-updating form
               if (cnd_w == CND_ALWF) begin
                  // (RQ5) (RQ6) flag update
                  flg_d = flag_update(flg_q, mv_src_w);
               end
            end
            // (RQ8) (RQ9) copy from CPU register
            OP_AUX_TO_FP, OP_TEMP_TO_FP: fp_d[dest_w] = mv_src_w;
            // (RQ11) copy to CPU register
            OP_FP_TO_AUX: aux_d[dest_w] = mv_src_w;
            // (RQ13) full status restore
            OP_LOAD_STAT: flg_d = frt_flags_t'(opnd_q[6:0]);
            OP_LOAD_COPY: begin
               // (RQ14) load, write two higher
               fp_d[dest_w] = mv_src_w;
               flg_d        = flag_update(flg_q, mv_src_w);
               copy_we_d    = 1'b1;
               copy_addr_d  = maddr_q + COPY_STEP;
               copy_data_d  = mv_src_w;
            end
            // (RQ15) (RQ16) (RQ17) immediate halves
            OP_IMM_HI, OP_IMM_LO: fp_d[dest_w] = mv_src_w;
            default: ;
         endcase
      end
   end

   // Read data taken from next-state values so a read right after a
   // write sees the new contents
   always_comb begin
      rdata_d = rdata_q;
      if (take && !hwrite_i) begin
         rdata_d = WORD_RST;
         case (haddr_i[7:0])
            ADDR_OPND:  rdata_d = opnd_d;
            ADDR_MADDR: rdata_d = maddr_d;
            ADDR_STAT:  rdata_d = {25'h0000000, flg_d};
            ADDR_COPYA: rdata_d = copy_addr_d;
            ADDR_COPYD: rdata_d = copy_data_d;
            ADDR_TEMP:  rdata_d = tmp_d;
            default: begin
               if (haddr_i[7:5] == PAGE_FP) begin
                  rdata_d = fp_d[haddr_i[4:2]];
               end else if (haddr_i[7:5] == PAGE_AUX) begin
                  rdata_d = aux_d[haddr_i[4:2]];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < FP_N; i++) begin
            fp_q[i]  <= WORD_RST;
            aux_q[i] <= WORD_RST;
         end
         tmp_q       <= WORD_RST;
         opnd_q      <= WORD_RST;
         maddr_q     <= WORD_RST;
         flg_q       <= FLAGS_RST;
         copy_we_q   <= 1'b0;
         copy_addr_q <= WORD_RST;
         copy_data_q <= WORD_RST;
         wr_q        <= 1'b0;
         addr_q      <= 8'h00;
         rdata_q     <= WORD_RST;
      end else if (en_i) begin
         fp_q        <= fp_d;
         aux_q       <= aux_d;
         tmp_q       <= tmp_d;
         opnd_q      <= opnd_d;
         maddr_q     <= maddr_d;
         flg_q       <= flg_d;
         copy_we_q   <= copy_we_d;
         copy_addr_q <= copy_addr_d;
         copy_data_q <= copy_data_d;
         wr_q        <= wr_d;
         addr_q      <= addr_d;
         rdata_q     <= rdata_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [31:0] src_h_q;
   logic [31:0] dold_h_q;
   logic [2:0]  dest_h_q;
   logic [15:0] imm_h_q;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         src_h_q  <= WORD_RST;
         dold_h_q <= WORD_RST;
         dest_h_q <= 3'h0;
         imm_h_q  <= 16'h0000;
      end else begin
         src_h_q  <= mv_src_w;
         dold_h_q <= fp_q[dest_w];
         dest_h_q <= dest_w;
         imm_h_q  <= cmd.imm;
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   // Both move forms share the condition logic, so both are watched
   logic        mv_w;
   logic        upd_w;
   assign mv_w  = exec && (cmd.op inside {OP_MOVE_RR, OP_MOVE_MEM});
   assign upd_w = mv_w && cnd_w == CND_ALWF || exec && cmd.op == OP_LOAD_COPY;

   float_flags_a: assert property ( // (RQ5)
      upd_w |=> flg_q.zero == (src_h_q[30:23] == 8'h00) &&
      flg_q.neg == (src_h_q[31] && src_h_q[30:23] != 8'h00))
      else $error("float flags wrong after flag-updating move");
   int_flags_a: assert property ( // (RQ6)
      upd_w |=> flg_q.izero == (src_h_q == 32'h0000_0000) &&
      flg_q.ineg == src_h_q[31])
      else $error("integer flags wrong after flag update");
   default_cond_a: assert property ( // (RQ3)
      mv_w && !cmd.has_cond |=>
      fp_q[dest_h_q] == src_h_q && flg_q.izero == (src_h_q == 32'h0))
      else $error("move without condition did not update flags");
   cond_keep_a: assert property ( // (RQ4)
      mv_w && cnd_w != CND_ALWF |=> $stable(flg_q))
      else $error("conditional move changed status flags");
   false_cond_a: assert property ( // (RQ1)
      mv_w && cnd_w == CND_EQ && !flg_q.zero |=> fp_q[dest_h_q] == dold_h_q)
      else $error("move taken although condition false");
   reserved_cond_a: assert property ( // (RQ2)
      mv_w && cnd_w inside {4'h6, 4'h7, 4'h8, 4'h9} |=>
      fp_q[dest_h_q] == dold_h_q && $stable(flg_q))
      else $error("reserved condition changed state");
   move_next_a: assert property ( // (RQ7)
      mv_w && cnd_w == CND_ALW |=> fp_q[dest_h_q] == src_h_q)
      else $error("move result not present next cycle");
   cpu_to_fp_a: assert property ( // (RQ8)
      exec && cmd.op inside {OP_AUX_TO_FP, OP_TEMP_TO_FP} |=>
      fp_q[dest_h_q] == src_h_q && $stable(flg_q))
      else $error("CPU register copy into float register wrong");
   temp_copy_a: assert property ( // (RQ9)
      exec && cmd.op == OP_TEMP_TO_FP |=> fp_q[dest_h_q] == tmp_q)
      else $error("temporary register copy wrong");
   fp_to_aux_a: assert property ( // (RQ11)
      exec && cmd.op == OP_FP_TO_AUX |=>
      aux_q[dest_h_q] == src_h_q && $stable(flg_q))
      else $error("float to auxiliary copy wrong");
   stat_load_a: assert property ( // (RQ13)
      exec && cmd.op == OP_LOAD_STAT |=> flg_q == src_h_q[6:0])
      else $error("status load did not overwrite flags");
   load_copy_a: assert property ( // (RQ14)
      exec && cmd.op == OP_LOAD_COPY |=> copy_we_o &&
      copy_addr_o == maddr_q + COPY_STEP && copy_data_o == src_h_q ##1
      !copy_we_o || !en_i)
      else $error("load with copy write wrong");
   imm_hi_a: assert property ( // (RQ16)
      exec && cmd.op == OP_IMM_HI |=>
      fp_q[dest_h_q] == {imm_h_q, 16'h0000} && $stable(flg_q))
      else $error("upper-half immediate wrong");
   imm_lo_a: assert property ( // (RQ17)
      exec && cmd.op == OP_IMM_LO |=>
      fp_q[dest_h_q] == {dold_h_q[31:16], imm_h_q} && $stable(flg_q))
      else $error("lower-half immediate wrong");

   flag_move_c: cover property (upd_w);
   load_copy_c: cover property (copy_we_o);
   imm_pair_c: cover property (
      exec && cmd.op == OP_IMM_HI ##[1:20] exec && cmd.op == OP_IMM_LO);
endmodule

`default_nettype wire

// File: sim/frt_mem_model.sv
// Memory side model that takes the load-with-copy write
`timescale 1ns/10ps
`default_nettype none

module frt_mem_model (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] data_i,
   output logic [31:0]      last_addr_o,
   output logic [31:0]      last_data_o,
   output logic [7:0]       writes_o
);
   // ----------------------------------------
   // Write capture
   // ----------------------------------------
   // copy lands in memory
   // Only the last write is kept; the count exposes extra or lost pulses
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         last_addr_o <= 32'h0000_0000;
         last_data_o <= 32'h0000_0000;
         writes_o    <= 8'h00;
      end else if (we_i) begin
         last_addr_o <= addr_i;
         last_data_o <= data_i;
         writes_o    <= writes_o + 8'h01;
      end
   end
endmodule

`default_nettype wire

// File: sim/fpu_register_transfer_tb.sv
// Self-checking bench for the register transfer unit
`timescale 1ns/10ps
`default_nettype none

module fpu_register_transfer_tb;
   import frt_pkg::*;
   logic        clock_i = 1'h0, resetn_i = 1'h0, en_i = 1'h1;
   logic        hsel_i = 1'h0, hwrite_i = 1'h0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic [2:0]  hsize_i = 3'h2;
   logic        hreadyout_o, hresp_o, copy_we_o;
   logic [31:0] hrdata_o, copy_addr_o, copy_data_o, m_addr, m_data;
   logic [7:0]  m_writes;
   frt_flags_t  flags_o, ef, sf;
   int          bad_count = 0;
   int          total_checks = 0;
   logic [31:0] vals [4] = '{32'h8080_0000, 32'h8000_0000, 32'h0000_0000,
                             32'h0000_0001};

   always #2 clock_i = ~clock_i;

   frt_core DUT (.clock_i(clock_i), .resetn_i(resetn_i), .en_i(en_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .copy_we_o(copy_we_o), .copy_addr_o(copy_addr_o),
      .copy_data_o(copy_data_o), .flags_o(flags_o));

   frt_mem_model MEM (.clock_i(clock_i), .resetn_i(resetn_i),
      .we_i(copy_we_o), .addr_i(copy_addr_o), .data_i(copy_data_o),
      .last_addr_o(m_addr), .last_data_o(m_data), .writes_o(m_writes));

   // ----------------------------------------
   // Reporting and comparisons
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk32(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h got %h", nm, e, g);
      end
   endtask

   // Flags are sampled mid-cycle so the executing edge has landed
   task automatic chkf(input string nm, input frt_flags_t e);
      @(negedge clock_i);
      total_checks++;
      if (flags_o !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h got %h", nm, e, flags_o);
      end
      @(posedge clock_i);
   endtask

   // ----------------------------------------
   // Bus master, entered right after a rising edge
   // ----------------------------------------
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (hreadyout_o !== 1'h1 && n < 64);
      if (hreadyout_o !== 1'h1) begin
         bad_count++;
         $display("[ERR] hready expected 1 got %b", hreadyout_o);
         give_verdict();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel_i   <= 1'h1;
      haddr_i  <= {24'h00_0000, a};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      wait_ready();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_ready();
      q = hrdata_o;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk32(nm, e, q);
   endtask

   task automatic cmd(input logic [3:0] op, input logic [3:0] cnd,
                      input logic [2:0] dst, input logic [2:0] src,
                      input logic hc, input logic [15:0] imm);
      frt_cmd_t c;
      c = '{imm, hc, src, 1'h0, dst, cnd, op};
      wr(ADDR_CMD, c);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic setf(input frt_flags_t f);
      wr(ADDR_OPND, {25'h0, f});
      cmd(OP_LOAD_STAT, CND_ALW, 3'h0, 3'h0, 1'h1, 16'h0);
   endtask

   task automatic loadfp(input logic [2:0] d, input logic [31:0] v,
                         input logic [3:0] cnd);
      wr(ADDR_OPND, v);
      cmd(OP_MOVE_MEM, cnd, d, 3'h0, 1'h1, 16'h0);
   endtask

   // ----------------------------------------
   // Reference behaviour
   // ----------------------------------------
   function automatic logic ctrue(input logic [3:0] c, input frt_flags_t f);
      case (c)
         CND_NEQ:           return !f.zero;
         CND_EQ:            return f.zero;
         CND_GT:            return !f.zero && !f.neg;
         CND_GEQ:           return !f.neg;
         CND_LT:            return f.neg;
         CND_LEQ:           return f.zero || f.neg;
         CND_TSET:          return f.test;
         CND_TCLR:          return !f.test;
         CND_LU:            return f.unf;
         CND_LV:            return f.ovf;
         CND_ALW, CND_ALWF: return 1'h1;
         default:           return 1'h0;
      endcase
   endfunction

   function automatic frt_flags_t upd(input frt_flags_t f,
                                      input logic [31:0] w);
      f.neg  = w[31];
      f.zero = 1'h0;
      if (w[30:23] == 8'h00) begin
         f.zero = 1'h1;
         f.neg  = 1'h0;
      end
      f.ineg  = w[31];
      f.izero = (w == 32'h0);
      return f;
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'h1;
      @(posedge clock_i);
      rdchk("status rst", ADDR_STAT, 32'h0);
      rdchk("fp0 rst", 8'h20, 32'h0);
      chk32("hresp", 32'h0, {31'h0, hresp_o});
      ef = 7'h43;
      loadfp(3'h1, 32'h1234_5678, CND_ALW);
      setf(ef);
      cmd(OP_IMM_HI, CND_ALWF, 3'h1, 3'h0, 1'h1, 16'hBFC0);
      rdchk("imm hi", 8'h24, 32'hBFC0_0000);
      cmd(OP_IMM_LO, CND_ALWF, 3'h1, 3'h0, 1'h1, 16'h0FDB);
      rdchk("imm lo", 8'h24, 32'hBFC0_0FDB);
      chkf("imm flags", ef);
      // Every condition code, once with all flags clear and once all set
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 16; c++) begin
            loadfp(3'h3, 32'h3F80_0000, CND_ALW);
            sf = s ? 7'h7F : 7'h00;
            setf(sf);
            rdchk("status", ADDR_STAT, {25'h0, sf});
            loadfp(3'h3, 32'hC0B0_0000, c[3:0]);
            rdchk("cond move", 8'h2C,
                  ctrue(c[3:0], sf) ? 32'hC0B0_0000 : 32'h3F80_0000);
            chkf("cond flags", (c == 15) ? upd(sf, 32'hC0B0_0000) : sf);
         end
      end
      // No condition given: flags must follow the moved word
      setf(ef);
      foreach (vals[i]) begin
         wr(ADDR_OPND, vals[i]);
         cmd(OP_MOVE_MEM, CND_NEQ, 3'h5, 3'h0, 1'h0, 16'h0);
         ef = upd(ef, vals[i]);
         chkf("update flags", ef);
         rdchk("fp5", 8'h34, vals[i]);
      end
      cmd(OP_MOVE_RR, CND_ALW, 3'h6, 3'h5, 1'h1, 16'h0);
      rdchk("fp to fp", 8'h38, 32'h0000_0001);
      wr(8'h4C, 32'hA5A5_5A5A);
      cmd(OP_AUX_TO_FP, CND_ALWF, 3'h2, 3'h3, 1'h1, 16'h0);
      idle(4);
      rdchk("aux to fp", 8'h28, 32'hA5A5_5A5A);
      chkf("aux flags", ef);
      wr(ADDR_TEMP, 32'h1357_9BDF);
      cmd(OP_TEMP_TO_FP, CND_ALWF, 3'h4, 3'h0, 1'h1, 16'h0);
      idle(4);
      rdchk("temp to fp", 8'h30, 32'h1357_9BDF);
      chkf("temp flags", ef);
      idle(1);
      cmd(OP_FP_TO_AUX, CND_ALWF, 3'h5, 3'h2, 1'h1, 16'h0);
      rdchk("fp to aux", 8'h54, 32'hA5A5_5A5A);
      chkf("fp to aux flags", ef);
      wr(ADDR_MADDR, 32'h0000_0100);
      wr(ADDR_OPND, 32'h8110_0000);
      cmd(OP_LOAD_COPY, CND_ALW, 3'h7, 3'h0, 1'h1, 16'h0);
      ef = upd(ef, 32'h8110_0000);
      chkf("copy flags", ef);
      rdchk("copy fp7", 8'h3C, 32'h8110_0000);
      rdchk("copy addr", ADDR_COPYA, 32'h0000_0102);
      rdchk("copy data", ADDR_COPYD, 32'h8110_0000);
      chk32("mem addr", 32'h0000_0102, m_addr);
      chk32("mem data", 32'h8110_0000, m_data);
      chk32("mem writes", 32'h1, {24'h0, m_writes});
      wr(8'hFC, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'hFC, 32'h0);
      wr(ADDR_STAT, 32'h0000_007F);
      rdchk("status ro", ADDR_STAT, {25'h0, ef});
      en_i <= 1'h0;
      @(negedge clock_i);
      chk32("frozen ready", 32'h0, {31'h0, hreadyout_o});
      @(posedge clock_i);
      en_i <= 1'h1;
      resetn_i <= 1'h0;
      @(posedge clock_i);
      resetn_i <= 1'h1;
      @(posedge clock_i);
      rdchk("fp7 rerst", 8'h3C, 32'h0);
      chkf("flags rerst", FLAGS_RST);
      give_verdict();
   end
endmodule

`default_nettype wire
